// ---- rtl/htr_pkg.sv ----
// Constants, types and register map of the HDLC transmit FIFO and receive routing block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package htr_pkg;

	localparam int unsigned ADDR_W = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TX_INFO     = 8'hB6;
	localparam logic [7:0] IDX_TX_FIFO     = 8'hB7;
	localparam logic [7:0] IDX_RX_ROUTE1   = 8'hB8;
	localparam logic [7:0] IDX_RX_SUPPRESS = 8'hB9;
	localparam logic [7:0] IDX_RX_CTRL2    = 8'hBC;

	localparam logic [ADDR_W-1:0] ADDR_TX_INFO     = {2'h0, IDX_TX_INFO, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_TX_FIFO     = {2'h0, IDX_TX_FIFO, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RX_ROUTE1   = {2'h0, IDX_RX_ROUTE1, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RX_SUPPRESS = {2'h0, IDX_RX_SUPPRESS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RX_CTRL2    = {2'h0, IDX_RX_CTRL2, 2'h0};

	// Field positions
	localparam int unsigned TXI_EMPTY_BIT = 2;
	localparam int unsigned TXI_FULL_BIT  = 1;
	localparam int unsigned TXI_UDR_BIT   = 0;
	localparam int unsigned RR1_SRC_BIT   = 7;
	localparam int unsigned RR1_SADS_BIT  = 6;
	localparam int unsigned RR1_MODE_BIT  = 5;
	localparam int unsigned RR1_CHAN_MSB  = 4;
	localparam int unsigned RR1_CHAN_LSB  = 0;
	localparam int unsigned RC2_SA_MSB    = 7;
	localparam int unsigned RC2_SA_LSB    = 3;
	localparam int unsigned TX_LAST_BIT   = 8;

	// Reset values
	localparam logic [7:0] RR1_RESET  = 8'h00;
	localparam logic [7:0] RSUP_RESET = 8'h00;
	localparam logic [7:0] RC2_RESET  = 8'h00;
	localparam logic       TX_IDLE_LEVEL = 1'b1;

	// Transmit FIFO and HDLC line patterns
	localparam int unsigned TX_FIFO_DEPTH = 64;
	localparam int unsigned TX_FIFO_WIDTH = 9;
	localparam logic [7:0]  HDLC_FLAG  = 8'h7E;
	localparam logic [7:0]  HDLC_ABORT = 8'hFF;
	localparam logic [2:0]  STUFF_RUN  = 3'h5;
	localparam logic [2:0]  LAST_BIT_CNT = 3'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_DATA  = 2'h1,
		TX_ABORT = 2'h3
	} htr_tx_state_t;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_TX_INFO,
		REG_TX_FIFO,
		REG_RR1,
		REG_RSUP,
		REG_RC2
	} htr_reg_t;

endpackage : htr_pkg

// ---- rtl/htr_fifo_if.sv ----
// Handshake bundle between the transmit FIFO and its user
`timescale 1ns/1ps
`default_nettype none
interface htr_fifo_if #(parameter int unsigned WIDTH = 9);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport source (output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data);
	modport store (input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data);
endinterface : htr_fifo_if
`default_nettype wire

// ---- rtl/htr_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module htr_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	htr_fifo_if.store f
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wptr_reg;
	logic [AW-1:0]    rptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Ready drops only when no slot is left
	assign f.wr_ready = count_reg != FULL_CNT;
	assign f.rd_valid = count_reg != '0;
	assign f.rd_data  = mem_reg[rptr_reg];
	assign push = ce && f.wr_valid && f.wr_ready;
	assign pop  = ce && f.rd_valid && f.rd_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wptr_reg] <= f.wr_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (push)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= rptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			count_reg <= '0;
		else if (push && !pop)
			count_reg <= count_reg + 1'b1;
		else if (pop && !push)
			count_reg <= count_reg - 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_full_drop: assert property (
		(f.wr_valid && !f.wr_ready && !pop) |=> $stable(count_reg))
		else $error("write into full FIFO changed its level");
	a_level_grow: assert property (
		(push && !pop) |=> (count_reg == $past(count_reg) + 1'b1))
		else $error("accepted byte not counted");

endmodule : htr_fifo
`default_nettype wire

// ---- rtl/htr_top.sv ----
// HDLC transmit FIFO, bit sender and receive source routing
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module htr_top (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic [htr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [htr_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       tx_bit_req,
	output logic                            tx_bit,
	output logic                            tx_fifo_has_space_flag,
	input  wire logic                       rx_bit_strobe,
	input  wire logic                       rx_data_bit,
	input  wire logic [4:0]                 rx_timeslot,
	input  wire logic [2:0]                 rx_bit_index,
	input  wire logic                       rx_non_fas_frame,
	output logic                            hdlc_rx_valid,
	output logic                            hdlc_rx_bit
);
	import htr_pkg::*;

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	htr_fifo_if #(.WIDTH(TX_FIFO_WIDTH)) fifo ();

	logic [ADDR_W-1:0] aw_addr_reg;
	logic              aw_hold_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              w_hold_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	logic [1:0]        rresp_next;
	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              wr_fire;
	htr_reg_t          wr_sel;
	htr_reg_t          ar_sel;

	logic [7:0]        rr1_reg;
	logic [7:0]        rsup_reg;
	logic [7:0]        rc2_reg;
	logic              udr_reg;
	logic              udr_set;
	logic              udr_clr;

	htr_tx_state_t     tx_state_reg;
	logic [7:0]        tx_shift_reg;
	logic [2:0]        tx_cnt_reg;
	logic [2:0]        tx_ones_reg;
	logic              tx_last_reg;
	logic              tx_bit_reg;
	logic              stuff;
	logic              slot;
	logic              boundary;
	logic              ends_msg;
	logic              take;

	logic              rx_pick;
	logic              rx_valid_reg;
	logic              rx_bit_reg;

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	function automatic htr_reg_t reg_decode(
		input logic [ADDR_W-1:0] a
	);
		if (a == ADDR_TX_INFO)
			return REG_TX_INFO;
		else if (a == ADDR_TX_FIFO)
			return REG_TX_FIFO;
		else if (a == ADDR_RX_ROUTE1)
			return REG_RR1;
		else if (a == ADDR_RX_SUPPRESS)
			return REG_RSUP;
		else if (a == ADDR_RX_CTRL2)
			return REG_RC2;
		else
			return REG_NONE;
	endfunction : reg_decode

	// Sa bits sit in bits 4..8 of timeslot 0 of non-FAS frames;
	// select bit k enables the bit of weight index k
	function automatic logic sa_hit(
		input logic [4:0] sel,
		input logic [4:0] ts,
		input logic [2:0] idx,
		input logic       nfas
	);
		logic [7:0] wide;
		wide = {3'h0, sel};
		return (ts == 5'h00) && nfas && wide[idx];
	endfunction : sa_hit

	//------------------------------------------------------------------
	// AXI4-Lite write channel
	//------------------------------------------------------------------
	assign s_axi_awready = ce && !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = ce && !w_hold_reg && !bvalid_reg;
	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign wr_fire = ce && aw_hold_reg && w_hold_reg;
	assign wr_sel  = reg_decode(aw_addr_reg);
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (aw_hs) begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_hold_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (w_hs) begin
			w_hold_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wr_sel == REG_NONE) ? RESP_DECERR
					: RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Control registers written through lane 0
	always_ff @(posedge clk) begin
		if (rst) begin
			rr1_reg  <= RR1_RESET;
			rsup_reg <= RSUP_RESET;
			rc2_reg  <= RC2_RESET;
		end else if (wr_fire && w_strb_reg[0]) begin
			if (wr_sel == REG_RR1)
				rr1_reg <= w_data_reg[7:0];
			else if (wr_sel == REG_RSUP)
				rsup_reg <= w_data_reg[7:0];
			else if (wr_sel == REG_RC2)
				rc2_reg <= w_data_reg[7:0];
		end
	end

	// One byte per FIFO port write; a full FIFO drops it
	assign fifo.wr_valid = wr_fire && w_strb_reg[0]
		&& (wr_sel == REG_TX_FIFO);
	assign fifo.wr_data = {w_data_reg[TX_LAST_BIT] && w_strb_reg[1],
		w_data_reg[7:0]};
	assign tx_fifo_has_space_flag = fifo.wr_ready;

	htr_fifo #(
		.WIDTH(TX_FIFO_WIDTH),
		.DEPTH(TX_FIFO_DEPTH)
	) u_fifo (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.f   (fifo.store)
	);

	//------------------------------------------------------------------
	// AXI4-Lite read channel
	//------------------------------------------------------------------
	assign s_axi_arready = ce && !rvalid_reg;
	assign ar_hs  = s_axi_arvalid && s_axi_arready;
	assign ar_sel = reg_decode(s_axi_araddr);
	assign udr_clr = ar_hs && (ar_sel == REG_TX_INFO);
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	always_comb begin
		rdata_next = '0;
		rresp_next = RESP_OKAY;
		if (ar_sel == REG_TX_INFO) begin
			rdata_next[TXI_EMPTY_BIT] = !fifo.rd_valid;
			rdata_next[TXI_FULL_BIT]  = !fifo.wr_ready;
			rdata_next[TXI_UDR_BIT]   = udr_reg;
		end else if (ar_sel == REG_RR1) begin
			rdata_next[7:0] = rr1_reg;
		end else if (ar_sel == REG_RSUP) begin
			rdata_next[7:0] = rsup_reg;
		end else if (ar_sel == REG_RC2) begin
			rdata_next[7:0] = rc2_reg;
		end else if (ar_sel == REG_NONE) begin
			rresp_next = RESP_DECERR;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rdata_next;
				rresp_reg  <= rresp_next;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Sticky underrun; a new event wins over the read clear
	always_ff @(posedge clk) begin
		if (rst)
			udr_reg <= 1'b0;
		else if (ce && udr_set)
			udr_reg <= 1'b1;
		else if (ce && udr_clr)
			udr_reg <= 1'b0;
	end

	//------------------------------------------------------------------
	// Transmit bit sender
	//------------------------------------------------------------------
	assign stuff    = tx_ones_reg == STUFF_RUN;
	assign slot     = ce && tx_bit_req;
	assign boundary = slot && !stuff && (tx_cnt_reg == LAST_BIT_CNT);
	assign ends_msg = (tx_state_reg == TX_DATA) && tx_last_reg;
	assign udr_set  = boundary && (tx_state_reg == TX_DATA)
		&& !tx_last_reg && !fifo.rd_valid;
	assign take = boundary && !ends_msg && (tx_state_reg != TX_ABORT)
		&& fifo.rd_valid;
	assign fifo.rd_ready = take;
	assign tx_bit = tx_bit_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_bit_reg  <= TX_IDLE_LEVEL;
			tx_ones_reg <= '0;
		end else if (slot) begin
			if (stuff) begin
				tx_bit_reg  <= 1'b0;
				tx_ones_reg <= '0;
			end else begin
				tx_bit_reg <= tx_shift_reg[0];
				if (tx_state_reg == TX_DATA && tx_shift_reg[0])
					tx_ones_reg <= tx_ones_reg + 1'b1;
				else
					tx_ones_reg <= '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= HDLC_FLAG;
			tx_cnt_reg   <= '0;
			tx_last_reg  <= 1'b0;
		end else if (slot && !stuff) begin
			tx_cnt_reg   <= tx_cnt_reg + 1'b1;
			tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
			if (boundary) begin
				case (tx_state_reg)
					TX_DATA: begin
						if (ends_msg) begin
							tx_state_reg <= TX_IDLE;
							tx_shift_reg <= HDLC_FLAG;
						end else if (udr_set) begin
							tx_state_reg <= TX_ABORT;
							tx_shift_reg <= HDLC_ABORT;
						end else begin
							tx_shift_reg <= fifo.rd_data[7:0];
							tx_last_reg  <= fifo.rd_data[TX_LAST_BIT];
						end
					end
					TX_IDLE: begin
						if (take) begin
							tx_state_reg <= TX_DATA;
							tx_shift_reg <= fifo.rd_data[7:0];
							tx_last_reg  <= fifo.rd_data[TX_LAST_BIT];
						end else begin
							tx_shift_reg <= HDLC_FLAG;
						end
					end
					default: begin
						tx_state_reg <= TX_IDLE;
						tx_shift_reg <= HDLC_FLAG;
					end
				endcase
			end
		end
	end

	//------------------------------------------------------------------
	// Receive source routing
	//------------------------------------------------------------------
	always_comb begin
		if (!rr1_reg[RR1_SRC_BIT])
			rx_pick = sa_hit(rc2_reg[RC2_SA_MSB:RC2_SA_LSB],
				rx_timeslot, rx_bit_index, rx_non_fas_frame);
		else if (!rr1_reg[RR1_SADS_BIT])
			rx_pick = sa_hit(rr1_reg[RR1_CHAN_MSB:RR1_CHAN_LSB],
				rx_timeslot, rx_bit_index, rx_non_fas_frame);
		else if (!rr1_reg[RR1_MODE_BIT])
			rx_pick = (rx_timeslot
				== rr1_reg[RR1_CHAN_MSB:RR1_CHAN_LSB])
				&& !rsup_reg[rx_bit_index];
		else
			rx_pick = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_valid_reg <= 1'b0;
			rx_bit_reg   <= 1'b0;
		end else if (ce) begin
			rx_valid_reg <= rx_bit_strobe && rx_pick;
			if (rx_bit_strobe)
				rx_bit_reg <= rx_data_bit;
		end
	end

	assign hdlc_rx_valid = rx_valid_reg;
	assign hdlc_rx_bit   = rx_bit_reg;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_info_read;
		udr_clr;
	endsequence

	sequence s_ts_slot;
		ce && rx_bit_strobe && rr1_reg[RR1_SRC_BIT]
			&& rr1_reg[RR1_SADS_BIT] && !rr1_reg[RR1_MODE_BIT]
			&& (rx_timeslot == rr1_reg[RR1_CHAN_MSB:RR1_CHAN_LSB]);
	endsequence

	a_empty_live: assert property (
		(s_info_read and ce) |=> s_axi_rvalid
			&& (s_axi_rdata[TXI_EMPTY_BIT] == $past(!fifo.rd_valid)))
		else $error("empty bit does not match FIFO");
	a_full_live: assert property (
		(s_info_read and ce) |=> s_axi_rvalid
			&& (s_axi_rdata[TXI_FULL_BIT] == $past(!fifo.wr_ready)))
		else $error("full bit does not match FIFO");
	a_underrun_abort: assert property (
		udr_set |=> (tx_state_reg == TX_ABORT) && udr_reg
			&& (tx_shift_reg == HDLC_ABORT))
		else $error("underrun did not start abort");
	a_udr_sticky: assert property (
		(udr_reg && !udr_clr) |=> udr_reg)
		else $error("underrun flag dropped without read");
	a_udr_clear: assert property (
		(s_info_read and ce && !udr_set)
			|=> !udr_reg)
		else $error("underrun flag not cleared by read");
	a_byte_order: assert property (
		take |=> (tx_shift_reg == $past(fifo.rd_data[7:0])))
		else $error("queued byte not loaded whole");
	a_ts_pick: assert property (
		(s_ts_slot and !rsup_reg[rx_bit_index]) |=> hdlc_rx_valid
			&& (hdlc_rx_bit == $past(rx_data_bit)))
		else $error("selected timeslot bit not routed");
	a_bit_suppress: assert property (
		(s_ts_slot and rsup_reg[rx_bit_index]) |=> !hdlc_rx_valid)
		else $error("suppressed timeslot bit was routed");

endmodule : htr_top
`default_nettype wire

// ---- tb/htr_frame_model.sv ----
// Far-side model: bit-slot pulses, transmit capture, receive strobes
`timescale 1ns/1ps
`default_nettype none
module htr_frame_model (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  run,
	input  wire logic  tx_bit,
	output logic       tx_bit_req,
	output logic       rx_bit_strobe,
	output logic       rx_data_bit,
	output logic [4:0] rx_timeslot,
	output logic [2:0] rx_bit_index,
	output logic       rx_non_fas_frame
);
	logic [1:0] div_reg;
	logic       req_d_reg;
	logic       log_bits [0:511];
	int         n_bits;

	// One slot pulse every fourth cycle while running
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			div_reg    <= 2'h0;
			tx_bit_req <= 1'b0;
		end else begin
			div_reg    <= div_reg + 2'h1;
			tx_bit_req <= (div_reg == 2'h3);
		end
	end

	// Logs the line bit one edge after its slot, once it has settled
	always_ff @(posedge clk) begin
		req_d_reg <= tx_bit_req;
		if (rst) begin
			n_bits <= 0;
		end else if (req_d_reg && n_bits < 512) begin
			log_bits[n_bits] <= tx_bit;
			n_bits           <= n_bits + 1;
		end
	end

	initial begin
		rx_bit_strobe    = 1'b0;
		rx_data_bit      = 1'b0;
		rx_timeslot      = 5'h00;
		rx_bit_index     = 3'h0;
		rx_non_fas_frame = 1'b0;
	end

	// One received bit; data, timeslot and index lines are scrambled once the strobe is gone
	task automatic send_rx(input logic [4:0] t, input logic [2:0] i,
		input logic nf, input logic b);
		@(posedge clk);
		rx_timeslot      <= t;
		rx_bit_index     <= i;
		rx_non_fas_frame <= nf;
		rx_data_bit      <= b;
		rx_bit_strobe    <= 1'b1;
		@(posedge clk);
		rx_bit_strobe    <= 1'b0;
		rx_data_bit      <= ~b;
		rx_timeslot      <= ~t;
		rx_bit_index     <= ~i;
	endtask : send_rx
endmodule : htr_frame_model
`default_nettype wire

// ---- tb/htr_top_tb.sv ----
// Self-checking bench of the HDLC transmit FIFO and receive routing
`timescale 1ns/1ps
`default_nettype none
module htr_top_tb;
	import htr_pkg::*;
	logic              clk, rst, run, awvalid, wvalid, bready;
	logic              arvalid, rready, awready, wready, bvalid;
	logic              arready, rvalid, tx_bit, tx_req, has_space;
	logic              strobe, rbit, nfas, rvld, rhb;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, rd;
	logic [1:0]        bresp, rresp, rs;
	logic [4:0]        ts;
	logic [2:0]        idx;
	int                n_fail, n_tests, k;

	htr_top DUT (.clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_bit_req(tx_req), .tx_bit(tx_bit),
		.tx_fifo_has_space_flag(has_space), .rx_bit_strobe(strobe),
		.rx_data_bit(rbit), .rx_timeslot(ts), .rx_bit_index(idx),
		.rx_non_fas_frame(nfas), .hdlc_rx_valid(rvld), .hdlc_rx_bit(rhb));

	htr_frame_model P (.clk(clk), .rst(rst), .run(run), .tx_bit(tx_bit),
		.tx_bit_req(tx_req), .rx_bit_strobe(strobe), .rx_data_bit(rbit),
		.rx_timeslot(ts), .rx_bit_index(idx), .rx_non_fas_frame(nfas));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------
	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wchk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		chk(rs, er);
	endtask : wchk

	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rdr

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		rdr(a);
		chk(rd & m, e);
		chk(rs, er);
	endtask : rchk

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	task automatic route(input logic [7:0] r1, input logic [7:0] sup,
		input logic [7:0] c2, input logic [4:0] t, input logic [2:0] i,
		input logic nf, input logic b, input logic ex);
		wchk(ADDR_RX_ROUTE1, {24'h0, r1}, RESP_OKAY);
		wchk(ADDR_RX_SUPPRESS, {24'h0, sup}, RESP_OKAY);
		wchk(ADDR_RX_CTRL2, {24'h0, c2}, RESP_OKAY);
		P.send_rx(t, i, nf, b);
		#1;
		chk(rvld, ex);
		if (ex) chk(rhb, b);
	endtask : route

	// Flag, then the byte, then eight ones, all sent LSB first
	function automatic int find_byte(input logic [7:0] b);
		logic [15:0] pat;
		int          m;
		pat = {b, HDLC_FLAG};
		find_byte = -1;
		for (int i = 0; i + 24 <= P.n_bits; i++) begin
			m = 0;
			for (int j = 0; j < 24; j++)
				if (P.log_bits[i+j] === (j < 16 ? pat[j] : 1'b1)) m++;
			if (m == 24 && find_byte < 0) find_byte = i;
		end
	endfunction : find_byte

	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		print_verdict;
	end

	//--------------------------------------------------------------
	// Tests
	//--------------------------------------------------------------
	initial begin
		{rst, run, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		awaddr = '0;
		araddr = '0;
		wdata  = 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rchk(ADDR_TX_INFO, 32'h7, 32'h4, RESP_OKAY);
		rchk(ADDR_RX_ROUTE1, 32'hFF, RR1_RESET, RESP_OKAY);
		rchk(ADDR_RX_SUPPRESS, 32'hFF, RSUP_RESET, RESP_OKAY);
		rchk(ADDR_RX_CTRL2, 32'hFF, RC2_RESET, RESP_OKAY);
		wchk(ADDR_RX_ROUTE1, 32'h5A, RESP_OKAY);
		rchk(ADDR_RX_ROUTE1, 32'hFF, 32'h5A, RESP_OKAY);
		wchk(ADDR_RX_SUPPRESS, 32'hA5, RESP_OKAY);
		rchk(ADDR_RX_SUPPRESS, 32'hFF, 32'hA5, RESP_OKAY);
		rchk(ADDR_TX_FIFO, 32'hFF, 32'h0, RESP_OKAY);
		wchk(12'h004, 32'h1, RESP_DECERR);
		rchk(12'h004, 32'hFFFFFFFF, 32'h0, RESP_DECERR);
		for (k = 0; k < 64; k++) begin
			#1 chk(has_space, 1'b1);
			wchk(ADDR_TX_FIFO, {23'h0, k == 63, k[7:0]}, RESP_OKAY);
		end
		#1 chk(has_space, 1'b0);
		rchk(ADDR_TX_INFO, 32'h7, 32'h2, RESP_OKAY);
		wchk(ADDR_TX_FIFO, 32'h1AA, RESP_OKAY);
		rchk(ADDR_TX_INFO, 32'h7, 32'h2, RESP_OKAY);
		run <= 1'b1;
		k = 0;
		do begin
			rdr(ADDR_TX_INFO);
			k++;
		end while (rd[2] !== 1'b1 && k < 1500);
		chk(rd[2:0], 3'h4);
		run <= 1'b0;
		do_reset;
		wchk(ADDR_TX_FIFO, 32'hA5, RESP_OKAY);
		run <= 1'b1;
		k = 0;
		do begin
			rdr(ADDR_TX_INFO);
			k++;
		end while (rd[0] !== 1'b1 && k < 200);
		chk(rd[2:0], 3'h5);
		rchk(ADDR_TX_INFO, 32'h1, 32'h0, RESP_OKAY);
		repeat (100) @(posedge clk);
		chk(find_byte(8'hA5) >= 0, 1'b1);
		route(8'h00, 8'h00, 8'h80, 5'd0, 3'd4, 1'b1, 1'b1, 1'b1);
		route(8'h00, 8'h00, 8'h80, 5'd0, 3'd3, 1'b1, 1'b1, 1'b0);
		route(8'h90, 8'h00, 8'h00, 5'd0, 3'd4, 1'b1, 1'b0, 1'b1);
		route(8'h81, 8'h00, 8'h00, 5'd0, 3'd0, 1'b1, 1'b1, 1'b1);
		route(8'h81, 8'h00, 8'hFF, 5'd0, 3'd1, 1'b1, 1'b1, 1'b0);
		rchk(ADDR_RX_CTRL2, 32'hFF, 32'hFF, RESP_OKAY);
		route(8'hC5, 8'h00, 8'h00, 5'd5, 3'd7, 1'b0, 1'b1, 1'b1);
		route(8'hC5, 8'h00, 8'h00, 5'd4, 3'd7, 1'b0, 1'b1, 1'b0);
		route(8'hC5, 8'h80, 8'h00, 5'd5, 3'd7, 1'b0, 1'b1, 1'b0);
		route(8'hC5, 8'h80, 8'h00, 5'd5, 3'd6, 1'b0, 1'b0, 1'b1);
		route(8'hD3, 8'h01, 8'h00, 5'd19, 3'd0, 1'b0, 1'b1, 1'b0);
		route(8'hD3, 8'h01, 8'h00, 5'd19, 3'd1, 1'b0, 1'b1, 1'b1);
		route(8'hE5, 8'h00, 8'h00, 5'd5, 3'd7, 1'b0, 1'b1, 1'b0);
		route(8'h00, 8'h00, 8'h80, 5'd0, 3'd4, 1'b0, 1'b1, 1'b0);
		print_verdict;
	end
endmodule : htr_top_tb
`default_nettype wire
